// file: egcs_pkg.sv
/*
 event-group channel select: shared constants
 assumes a 16-channel converter sequencer on one clock
*/
`default_nettype none
package egcs_pkg;
	localparam int          NUM_CH        = 16;
	localparam int          CH_W          = 4;
	localparam int          RES_W         = 12;
	localparam int          ADDR_W        = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_MASK      = 8'h0c;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h08;
	localparam logic [7:0]  OFS_RESULT0   = 8'h40;
	localparam logic [7:0]  OFS_RESULT15  = 8'h7c;
	// ctrl fields
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_POL_BIT  = 1;
	localparam int          CTRL_SRC_LO   = 2;
	localparam int          CTRL_W        = 4;
	localparam logic [3:0]  CTRL_RESET    = 4'h0;
	// status fields
	localparam int          ST_DONE_BIT   = 0;
	localparam int          ST_BUSY_BIT   = 1;
	localparam int          ST_W          = 1;
	localparam logic [15:0] MASK_RESET    = 16'h0000;
	// trigger sources
	localparam logic [1:0]  SRC_PIN       = 2'h0;
	localparam logic [1:0]  SRC_INT0      = 2'h1;
	localparam logic [1:0]  SRC_INT1      = 2'h2;
	localparam logic [1:0]  SRC_INT2      = 2'h3;
	typedef enum logic [3:0] {
		EG_IDLE = 4'b0001,
		EG_WAIT = 4'b0010,
		EG_HOLD = 4'b0100,
		EG_CONV = 4'b1000
	} egcs_state_e;
endpackage
`default_nettype wire

// file: egcs_result_mem.sv
/*
 sixteen result words, one per channel, registered read
 assumes single clock, write and read ports independent
*/
`timescale 1ns/1ps
`default_nettype none
module egcs_result_mem #(
	parameter int W  = 12,
	parameter int N  = 16,
	parameter int AW = 4
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_idx,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_idx,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem_q [N];
	logic [W-1:0] rd_q;

	always_ff @(posedge ref_clk)
	begin
		if (ce && wr_en)
			mem_q[wr_idx] <= wr_data;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rd_q <= '0;
		else if (ce)
			rd_q <= mem_q[rd_idx];
	end

	assign rd_data = rd_q;
endmodule
`default_nettype wire

// file: egcs_sync.sv
/*
 three-stage input synchroniser with agreement filter
 assumes asynchronous input, one destination clock
*/
`timescale 1ns/1ps
`default_nettype none
module egcs_sync (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic async_in,
	output logic      sync_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	logic out_d;

	always_comb
	begin
		out_d = out_q;
		if (s2_q == s3_q)
			out_d = s2_q;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end
		else if (ce)
		begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule
`default_nettype wire

// file: egcs_top.sv
/*
 event-group channel select sequencer with register port
 assumes converter core answers conv_start with one conv_done
 pulse carrying result; other groups signal busy via group_busy
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module egcs_top
	import egcs_pkg::*;
#(
	parameter int RES_WIDTH = egcs_pkg::RES_W
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic [egcs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	input  wire logic                      external_trigger_pin,
	input  wire logic [2:0]                internal_trigger,
	input  wire logic                      group_busy,
	output logic                           conv_start,
	output logic      [egcs_pkg::CH_W-1:0] conv_channel,
	input  wire logic                      conv_done,
	input  wire logic [RES_WIDTH-1:0]      conv_result,
	output logic                           irq
);
	import egcs_pkg::*;

	function automatic logic [4:0] next_sel(input logic [15:0] m,
		input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (m[i] && (5'(i) >= from))
				r = 5'(i);
		return r;
	endfunction

	function automatic logic is_reg(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	egcs_state_e        st_q, st_d;
	logic [15:0]        event_group_channel_mask_q, mask_d;
	logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic [ST_W-1:0]    irq_mask_q, irq_mask_d;
	logic               event_group_done_flag_q, done_d;
	logic [CH_W-1:0]    ch_q, ch_d;
	logic [CH_W:0]      cnt_q, cnt_d;
	logic               trig_q, trig_d;
	logic               start_q, start_d;
	logic [31:0]        rdata_q, rdata_d;
	logic               pin_sync;
	logic               src_lvl;
	logic               edge_hit;
	logic               module_en;
	logic               trigger_edge_polarity;
	logic [1:0]         trigger_source_select;
	logic               wr_mask;
	logic [4:0]         first_sel;
	logic [4:0]         after_sel;
	logic [CH_W-1:0]    mem_rd_idx;
	logic [RES_WIDTH-1:0] mem_rd_data;
	logic               rd_result_q;
	logic               rd_status;

	assign module_en             = ctrl_q[CTRL_EN_BIT];
	assign trigger_edge_polarity = ctrl_q[CTRL_POL_BIT];
	assign trigger_source_select = ctrl_q[CTRL_SRC_LO +: 2];
	assign wr_mask   = reg_wr && is_reg(reg_addr, OFS_MASK);
	assign rd_status = reg_rd && is_reg(reg_addr, OFS_STATUS);

	egcs_sync u_pin_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.ce       (ce),
		.async_in (external_trigger_pin),
		.sync_out (pin_sync)
	);

	always_comb
	begin
		unique case (trigger_source_select)
			SRC_PIN:  src_lvl = pin_sync;
			SRC_INT0: src_lvl = internal_trigger[0];
			SRC_INT1: src_lvl = internal_trigger[1];
			SRC_INT2: src_lvl = internal_trigger[2];
		endcase
	end

	// polarity 0 rising, 1 falling
	assign trig_d   = src_lvl;
	assign edge_hit = trigger_edge_polarity ? (trig_q && !src_lvl)
		: (!trig_q && src_lvl);

	assign first_sel = next_sel(event_group_channel_mask_q, 5'h00);
	assign after_sel = next_sel(mask_d, {1'b0, ch_q} + 5'h01);

	// register writes
	always_comb
	begin
		mask_d     = event_group_channel_mask_q;
		ctrl_d     = ctrl_q;
		irq_mask_d = irq_mask_q;
		if (reg_wr)
		begin
			if (is_reg(reg_addr, OFS_MASK))
				mask_d = reg_wdata[15:0];
			if (is_reg(reg_addr, OFS_CTRL))
				ctrl_d = reg_wdata[CTRL_W-1:0];
			if (is_reg(reg_addr, OFS_IRQ_MASK))
				irq_mask_d = reg_wdata[ST_W-1:0];
		end
	end

	// sequencer
	always_comb
	begin
		st_d    = st_q;
		ch_d    = ch_q;
		cnt_d   = cnt_q;
		start_d = 1'b0;
		done_d  = event_group_done_flag_q;
		if (rd_status || wr_mask)
			done_d = 1'b0;
		unique case (st_q)
			EG_IDLE:
			begin
				if (edge_hit && first_sel != 5'h10)
				begin
					ch_d  = first_sel[CH_W-1:0];
					cnt_d = first_sel;
					st_d  = EG_WAIT;
				end
			end
			EG_WAIT:
			begin
				if (group_busy)
					st_d = EG_HOLD;
				else if (cnt_q == '0)
				begin
					start_d = 1'b1;
					st_d    = EG_CONV;
				end
				else
					cnt_d = cnt_q - 5'h01;
			end
			EG_HOLD:
			begin
				if (!group_busy)
				begin
					start_d = 1'b1;
					st_d    = EG_CONV;
				end
			end
			EG_CONV:
			begin
				if (conv_done)
				begin
					if (after_sel == 5'h10)
					begin
						st_d   = EG_IDLE;
						done_d = 1'b1;
					end
					else
					begin
						ch_d    = after_sel[CH_W-1:0];
						start_d = 1'b1;
					end
				end
			end
		endcase
		// a start already queued must not leak out after an abort
		if (wr_mask && reg_wdata[15:0] == 16'h0000)
		begin
			st_d    = EG_IDLE;
			start_d = 1'b0;
		end
		if (!module_en)
		begin
			st_d    = EG_IDLE;
			start_d = 1'b0;
			done_d  = 1'b0;
		end
	end

	assign mem_rd_idx = reg_addr[CH_W+1:2];

	egcs_result_mem #(
		.W  (RES_WIDTH),
		.N  (NUM_CH),
		.AW (CH_W)
	) u_results (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.wr_en   (st_q == EG_CONV && conv_done),
		.wr_idx  (ch_q),
		.wr_data (conv_result),
		.rd_idx  (mem_rd_idx),
		.rd_data (mem_rd_data)
	);

	// read mux, data one cycle after strobe
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_rd)
		begin
			if (is_reg(reg_addr, OFS_MASK))
				rdata_d = {16'h0000, event_group_channel_mask_q};
			else if (is_reg(reg_addr, OFS_CTRL))
				rdata_d = {28'h0000000, ctrl_q};
			else if (is_reg(reg_addr, OFS_STATUS))
				rdata_d = {30'h0, st_q != EG_IDLE,
					event_group_done_flag_q};
			else if (is_reg(reg_addr, OFS_IRQ_MASK))
				rdata_d = {31'h0, irq_mask_q};
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q                       <= EG_IDLE;
			event_group_channel_mask_q <= MASK_RESET;
			ctrl_q                     <= CTRL_RESET;
			irq_mask_q                 <= '0;
			event_group_done_flag_q    <= 1'b0;
			ch_q                       <= '0;
			cnt_q                      <= '0;
			trig_q                     <= 1'b0;
			start_q                    <= 1'b0;
			rdata_q                    <= '0;
			rd_result_q                <= 1'b0;
		end
		else if (ce)
		begin
			st_q                       <= st_d;
			event_group_channel_mask_q <= mask_d;
			ctrl_q                     <= ctrl_d;
			irq_mask_q                 <= irq_mask_d;
			event_group_done_flag_q    <= done_d;
			ch_q                       <= ch_d;
			cnt_q                      <= cnt_d;
			trig_q                     <= trig_d;
			start_q                    <= start_d;
			rdata_q                    <= rdata_d;
			rd_result_q                <= reg_rd
				&& reg_addr >= OFS_RESULT0 && reg_addr <= OFS_RESULT15;
		end
	end

	assign reg_rdata    = rd_result_q
		? {{(32-RES_WIDTH){1'b0}}, mem_rd_data} : rdata_q;
	assign conv_start   = start_q;
	assign conv_channel = ch_q;
	assign irq          = event_group_done_flag_q && irq_mask_q[ST_DONE_BIT];
endmodule
`default_nettype wire

// file: egcs_core_model.sv
/*
 converter core stand-in: one done pulse per start
 assumes start pulses from egcs_top on ref_clk
*/
`timescale 1ns/1ps
`default_nettype none
module egcs_core_model
	import egcs_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             slow,
	input  wire logic             conv_start,
	input  wire logic [CH_W-1:0]  conv_channel,
	output logic                  conv_done,
	output logic      [RES_W-1:0] conv_result
);
	logic [4:0] cnt_q;
	logic [3:0] ch_q;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		conv_done <= 1'b0;
		if (rst)
			cnt_q <= 5'h0;
		else if (conv_start)
		begin
			cnt_q <= slow ? 5'h0c : 5'h03;
			ch_q <= conv_channel;
		end
		else if (cnt_q != 5'h0)
		begin
			cnt_q <= cnt_q - 5'h1;
			conv_done <= cnt_q == 5'h1;
		end
	end
	// word names its channel; inverted when not valid
	assign conv_result = conv_done ? {8'h50, ch_q} : ~{8'h50, ch_q};
endmodule
`default_nettype wire

// file: egcs_assertions.sv
/*
 port checker for egcs_top
 assumes bound into egcs_top, one clock
*/
`timescale 1ns/1ps
`default_nettype none
module egcs_assertions
	import egcs_pkg::*;
(
	input wire logic                        ref_clk,
	input wire logic                        rst,
	input wire logic                        ce,
	input wire logic [egcs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0]                 reg_wdata,
	input wire logic                        reg_wr,
	input wire logic                        reg_rd,
	input wire logic [31:0]                 reg_rdata,
	input wire logic                        conv_start,
	input wire logic [egcs_pkg::CH_W-1:0]   conv_channel,
	input wire logic                        conv_done,
	input wire logic                        irq
);
	logic [15:0] mask_q;
	logic [15:0] mask_d;
	logic        mwr;
	assign mwr = ce && reg_wr && reg_addr == OFS_MASK;
	always_comb
	begin
		mask_d = mwr ? reg_wdata[15:0] : mask_q;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			mask_q <= 16'h0000;
		else
			mask_q <= mask_d;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_start_pulse: assert property (conv_start && ce |=> !conv_start)
		else $error("start pulse too long");
	a_select_bit: assert property (conv_start |-> mask_q[conv_channel])
		else $error("unselected channel started");
	a_zero_stops: assert property (
		mwr && reg_wdata[15:0] == 16'h0 |=> !conv_start [*8])
		else $error("start after zero mask");
	a_idle_quiet: assert property (
		mask_q == 16'h0 && $past(mask_q) == 16'h0 |-> !conv_start)
		else $error("start with empty mask");
	a_scan_ascends: assert property (
		conv_start && $past(conv_done) |-> conv_channel > $past(conv_channel))
		else $error("channel order not ascending");
	a_channel_holds: assert property (
		conv_start |=> $stable(conv_channel) [*3])
		else $error("channel moved during conversion");
	a_write_clears: assert property (
		mwr && !conv_done |=> !irq)
		else $error("mask write left done set");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	c_top_channel: cover property (conv_start && conv_channel == 4'hf);
	c_write_done: cover property (mwr && irq);
	c_irq_drop: cover property ($fell(irq));
endmodule
bind egcs_top egcs_assertions i_chk (.ref_clk(ref_clk), .rst(rst), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
	.conv_channel(conv_channel), .conv_done(conv_done), .irq(irq));
`default_nettype wire

// file: tb.sv
/*
 self-checking bench for egcs_top
 assumes egcs_core_model as converter core
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb;
	import egcs_pkg::*;
	typedef struct {logic [15:0] m; logic [3:0] c; int f;} egcs_row_s;
	egcs_row_s   rows[4] = '{'{16'h080a, 4'h1, 1}, '{16'h0001, 4'h7, 0},
		'{16'h8000, 4'h9, 15}, '{16'hffff, 4'hf, 0}};
	logic        ref_clk, rst, ce, reg_wr, reg_rd, pin, busy, slow, irq;
	logic        conv_start, conv_done;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_v;
	logic [2:0]  itrig;
	logic [3:0]  conv_channel;
	logic [11:0] conv_result;
	logic [3:0]  seen[$];
	int          mismatches, tests_run, cyc, base, lat, ofs, k;
	egcs_top i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_trigger_pin(pin), .internal_trigger(itrig),
		.group_busy(busy), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_done(conv_done),
		.conv_result(conv_result), .irq(irq));
	egcs_core_model i_core (.ref_clk(ref_clk), .rst(rst), .slow(slow),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_done(conv_done), .conv_result(conv_result));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (conv_start && seen.size() == 0)
			lat = cyc;
		if (conv_start)
			seen.push_back(conv_channel);
		if (cyc == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	// park lines at idle level, then one edge of the chosen polarity
	task automatic arm(input logic [3:0] c, input logic [15:0] m);
		wr(OFS_MASK, 32'h0);
		wr(OFS_CTRL, {28'h0, c});
		pin <= c[1];
		itrig <= {3{c[1]}};
		repeat (8) @(posedge ref_clk);
		seen.delete();
		wr(OFS_MASK, {16'h0, m});
		#1 base = cyc;
		if (c[3:2] == 2'h0)
			pin <= ~c[1];
		else
			itrig[c[3:2] - 2'h1] <= ~c[1];
	endtask
	task automatic wait_until(input bit want_irq, input int n);
		for (int t = 0; t < 400 && (want_irq ? irq !== 1'b1 : seen.size() < n);
			t++)
			@(posedge ref_clk);
		if (want_irq ? irq !== 1'b1 : seen.size() < n)
			mismatches++;
	endtask
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		{reg_wr, reg_rd, pin, busy, slow, itrig} = '0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFS_MASK);
		`CHK(rd_v, 32'h0)
		rd(8'hf0);
		`CHK(rd_v, 32'h0)
		wr(OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			arm(rows[i].c, rows[i].m);
			wait_until(1'b1, 0);
			`CHK(irq, 1'b1)
			k = 0;
			for (int ch = 0; ch < 16; ch++)
				if (rows[i].m[ch])
				begin
					`CHK(seen[k], ch[3:0])
					rd(OFS_RESULT0 + 8'(4 * ch));
					`CHK(rd_v, {20'h0, 8'h50, ch[3:0]})
					k++;
				end
			`CHK(seen.size(), k)
			if (i == 1)
				ofs = lat - base - rows[i].f;
			if (i > 1)
				`CHK(lat - base - rows[i].f, ofs)
			wr(OFS_MASK, {16'h0, rows[i].m});
			#1 `CHK(irq, 1'b0)
			$display("row %0d done", i);
		end
		seen.delete();
		itrig[2] <= 1'b1;
		repeat (20) @(posedge ref_clk);
		`CHK(seen.size(), 0)
		$display("polarity test done");
		slow <= 1'b1;
		arm(4'h5, 16'h00ff);
		wait_until(1'b0, 2);
		repeat (4) @(posedge ref_clk);
		wr(OFS_MASK, 32'h0);
		repeat (60) @(posedge ref_clk);
		`CHK(seen.size(), 2)
		`CHK(irq, 1'b0)
		$display("stop test done");
		arm(4'h5, 16'h00f0);
		wait_until(1'b0, 1);
		wr(OFS_MASK, 32'h0a0a);
		wait_until(1'b1, 0);
		`CHK(seen.size(), 3)
		`CHK(seen[1], 4'h9)
		`CHK(seen[2], 4'hb)
		$display("rewrite test done");
		busy <= 1'b1;
		arm(4'h1, 16'h0001);
		repeat (30) @(posedge ref_clk);
		`CHK(seen.size(), 0)
		busy <= 1'b0;
		wait_until(1'b0, 1);
		`CHK(seen.size(), 1)
		`CHK(seen[0], 4'h0)
		wait_until(1'b1, 0);
		`CHK(irq, 1'b1)
		$display("busy test done");
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CHK(irq, 1'b0)
		rd(OFS_MASK);
		`CHK(rd_v, 32'h0)
		$display("reset test done");
		complete_run();
	end
endmodule
`default_nettype wire
